// >>> inc/aux_irq_pkg.sv
// Purpose: constants and carriers for the auxiliary control and interrupt enable registers
// Assumes: 8-bit special-function register bus from the core
// Notes: bit positions and reset values of both registers
package aux_irq_pkg;
    localparam logic [7:0] AUX_CTRL_ADDR = 8'h8E;
    localparam logic [7:0] IRQ_EN_ADDR = 8'hA8;
    localparam int AUX_LOWCON_BIT = 6;
    localparam int AUX_XMEM_BIT = 1;
    localparam int AUX_ALE_OFF_BIT = 0;
    localparam int IE_GLOBAL_BIT = 7;
    localparam int IE_SERIAL_BIT = 4;
    localparam int IE_T1_BIT = 3;
    localparam int IE_X1_BIT = 2;
    localparam int IE_T0_BIT = 1;
    localparam int IE_X0_BIT = 0;
    localparam logic [7:0] AUX_WRITE_MASK = 8'h43;
    localparam logic [7:0] IE_WRITE_MASK = 8'h9F;
    localparam logic [7:0] AUX_RESET = 8'h00;
    localparam logic [7:0] IE_RESET = 8'h00;
    localparam int NUM_SRC = 5;

    // raw interrupt requests, one per source
    typedef struct packed {
        logic serial;
        logic timer1;
        logic ext1;
        logic timer0;
        logic ext0;
    } irq_src_t;

    // bus cycle types that may need the latch strobe
    typedef struct packed {
        logic internal_fetch;
        logic external_fetch;
        logic data_move;
        logic table_read;
    } cycle_kind_t;

    typedef enum {ALE_NORMAL, ALE_QUIET} ale_mode_t;
endpackage

// >>> sim/test_aux_irq_regs.sv
// Purpose: self-checking bench for the auxiliary and interrupt enable registers
// Assumes: one-cycle strobes, read data valid the cycle after the read edge
// Notes: random values from a fixed seed; a second reset is applied mid-run
`default_nettype none
module test_aux_irq_regs;
    timeunit 1ns;
    timeprecision 1ns;
    import aux_irq_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic [7:0] sfr_wdata = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic ale_pulse = 1'b0;
    logic rd_d = 1'b0;
    irq_src_t irq_req = '0;
    cycle_kind_t bus_cycle = '0;
    logic [7:0] sfr_rdata;
    logic sfr_hit, ale_out, ale_oe, low_consumption_select, external_xmem_select;
    irq_src_t irq_accept;
    logic [7:0] exp_q[$];
    logic [7:0] av, iv, rq;
    int miscompares = 0;
    int cmp_count = 0;
    always #20 sys_clk = ~sys_clk;
    aux_irq_regs u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .sfr_hit(sfr_hit), .irq_req(irq_req), .irq_accept(irq_accept),
        .bus_cycle(bus_cycle), .ale_pulse(ale_pulse), .ale_out(ale_out), .ale_oe(ale_oe),
        .low_consumption_select(low_consumption_select),
        .external_xmem_select(external_xmem_select));
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge sys_clk);
        sfr_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge sys_clk);
        sfr_rd <= 1'b0;
    endtask
    // pin outputs are combinational, so they are judged mid-cycle
    task automatic pins(input logic [7:0] a, input logic [7:0] ie);
        logic oe;
        logic [7:0] acc;
        @(negedge sys_clk);
        oe = !(a[0] && !(bus_cycle.external_fetch || bus_cycle.data_move || bus_cycle.table_read));
        check("lp", {7'h00, low_consumption_select}, {7'h00, a[6]});
        check("xmem", {7'h00, external_xmem_select}, {7'h00, a[1]});
        check("ale_oe", {7'h00, ale_oe}, {7'h00, oe});
        check("ale_out", {7'h00, ale_out}, {7'h00, oe & ale_pulse});
        acc = {3'h0, ie[4:0] & rq[4:0] & {5{ie[7]}}};
        check("accept", {3'h0, irq_accept}, acc);
    endtask
    always @(posedge sys_clk) rd_d <= sfr_rd;
    always @(negedge sys_clk)
        if (rd_d && exp_q.size() > 0)
            check("rdata", sfr_rdata, exp_q.pop_front());
    initial
    begin
        #200000;
        miscompares++;
        end_sim();
    end
    initial
    begin
        void'($urandom(81441));
        rq = 8'h00;
        repeat (8) @(posedge sys_clk);
        rst_b <= 1'b1;
        rd(AUX_CTRL_ADDR, AUX_RESET);
        rd(IRQ_EN_ADDR, IE_RESET);
        pins(8'h00, 8'h00);
        check("hit", {7'h00, sfr_hit}, 8'h01);
        repeat (40)
        begin
            av = 8'($urandom) & AUX_WRITE_MASK;
            iv = 8'($urandom) & IE_WRITE_MASK;
            rq = 8'($urandom);
            wr(AUX_CTRL_ADDR, av);
            wr(IRQ_EN_ADDR, iv);
            wr(8'h8F, 8'hFF);
            irq_req <= irq_src_t'(rq[4:0]);
            bus_cycle <= cycle_kind_t'(4'($urandom));
            ale_pulse <= 1'($urandom);
            rd(AUX_CTRL_ADDR, av & AUX_WRITE_MASK);
            rd(IRQ_EN_ADDR, iv & IE_WRITE_MASK);
            rd(8'h8F, 8'h00);
            pins(av, iv);
            check("hit", {7'h00, sfr_hit}, 8'h00);
        end
        // strobe quiet on an internal fetch, then kept for each external cycle kind
        wr(AUX_CTRL_ADDR, 8'h01);
        for (int k = 0; k < 4; k++)
        begin
            @(posedge sys_clk);
            bus_cycle <= cycle_kind_t'(4'h8 >> k);
            ale_pulse <= 1'b1;
            pins(8'h01, iv);
        end
        wr(AUX_CTRL_ADDR, AUX_WRITE_MASK);
        wr(IRQ_EN_ADDR, IE_WRITE_MASK);
        rd(AUX_CTRL_ADDR, AUX_WRITE_MASK);
        rd(IRQ_EN_ADDR, IE_WRITE_MASK);
        // second reset after nonzero contents must clear both registers again
        @(posedge sys_clk);
        rst_b <= 1'b0;
        @(posedge sys_clk);
        rst_b <= 1'b1;
        rd(AUX_CTRL_ADDR, 8'h00);
        rd(IRQ_EN_ADDR, 8'h00);
        pins(8'h00, 8'h00);
        // let the read checker take the last word before the run ends
        @(posedge sys_clk);
        end_sim();
    end
endmodule
`default_nettype wire

// >>> src/aux_irq_regs.sv
// Purpose: auxiliary control and interrupt enable special-function registers
// Assumes: core issues single-cycle reads and writes with an 8-bit address
// Notes: reserved bits are not stored and read back as zero
`default_nettype none

// How it works
// RQ1: bit 6 of the auxiliary register high selects low-consumption mode, low selects standard.
// RQ2: bit 1 of the auxiliary register sends expanded data memory accesses on-chip (0) or off-chip (1).
// RQ3: bit 0 of the auxiliary register high stops the latch strobe on internal code fetches.
// RQ4: reset clears auxiliary bits 7, 6, 1 and 0.
// RQ5: software never sets reserved bits and treats reserved read data as indeterminate.
// RQ6: a clear global enable blocks every interrupt source.
// RQ7: with the global enable set, each source follows its own enable bit.
// RQ8: interrupt-enable bit 4 gates the serial port interrupt.
// RQ9: bits 1 and 3 gate the timer 0 and timer 1 overflow interrupts.
// RQ10: bits 0 and 2 gate external interrupts 0 and 1.
// RQ11: reset clears the global enable and all five individual enables.
// RQ12: the strobe still pulses for external data moves, table reads and external fetches.
// RQ13: while the strobe is suppressed the pin is not driven, only weakly pulled high.
// RQ14: reserved-bit writes change nothing, and new values act from the next clock.
module aux_irq_regs
    import aux_irq_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit,
    input wire aux_irq_pkg::irq_src_t irq_req,
    output aux_irq_pkg::irq_src_t irq_accept,
    input wire aux_irq_pkg::cycle_kind_t bus_cycle,
    input wire logic ale_pulse,
    output logic ale_out,
    output logic ale_oe,
    output logic low_consumption_select,
    output logic external_xmem_select
);
    import aux_irq_pkg::*;

    logic [7:0] aux_ff;
    logic [7:0] ie_ff;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic [NUM_SRC-1:0] en_vec;
    logic [NUM_SRC-1:0] req_vec;
    logic [NUM_SRC-1:0] acc_vec;
    logic strobe_needed;
    ale_mode_t ale_mode;

    // the gate vector is indexed by source, so it must match the request struct
    if (NUM_SRC != $bits(irq_src_t))
    begin : g_bad_src_count
        $error("source count does not match the request struct");
    end

    // each mask keeps exactly the defined control bits and drops the reserved ones
    if (AUX_WRITE_MASK != ((8'h01 << AUX_LOWCON_BIT) | (8'h01 << AUX_XMEM_BIT)
                           | (8'h01 << AUX_ALE_OFF_BIT)))
    begin : g_bad_aux_mask
        $error("auxiliary write mask does not match its control bits");
    end

    if (IE_WRITE_MASK != ((8'h01 << IE_GLOBAL_BIT) | (8'h01 << IE_SERIAL_BIT)
                          | (8'h01 << IE_T1_BIT) | (8'h01 << IE_X1_BIT)
                          | (8'h01 << IE_T0_BIT) | (8'h01 << IE_X0_BIT)))
    begin : g_bad_ie_mask
        $error("interrupt enable write mask does not match its enable bits");
    end

    // reserved bits masked so they never reach state
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            aux_ff <= AUX_RESET; // RQ4
        else if (sfr_wr && sfr_addr == AUX_CTRL_ADDR)
            aux_ff <= sfr_wdata & AUX_WRITE_MASK; // RQ14
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            ie_ff <= IE_RESET; // RQ11
        else if (sfr_wr && sfr_addr == IRQ_EN_ADDR)
            ie_ff <= sfr_wdata & IE_WRITE_MASK; // RQ14
    end

    // unmapped reads return zero; without a read strobe the last word stays on the bus
    always_comb
    begin
        nxt_rdata = rdata_ff;
        if (sfr_rd)
        begin
            case (sfr_addr)
                AUX_CTRL_ADDR: nxt_rdata = aux_ff;
                IRQ_EN_ADDR: nxt_rdata = ie_ff;
                default: nxt_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            rdata_ff <= '0;
        else
            rdata_ff <= nxt_rdata;
    end

    assign sfr_rdata = rdata_ff;
    assign sfr_hit = (sfr_addr == AUX_CTRL_ADDR) || (sfr_addr == IRQ_EN_ADDR);

    assign low_consumption_select = aux_ff[AUX_LOWCON_BIT]; // RQ1
    assign external_xmem_select = aux_ff[AUX_XMEM_BIT]; // RQ2

    assign en_vec = {ie_ff[IE_SERIAL_BIT], ie_ff[IE_T1_BIT], ie_ff[IE_X1_BIT],
                     ie_ff[IE_T0_BIT], ie_ff[IE_X0_BIT]}; // RQ8 RQ9 RQ10
    assign req_vec = irq_req;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_SRC; gi++)
        begin : g_gate
            // one gate per source, all under the global enable
            assign acc_vec[gi] = req_vec[gi] & en_vec[gi] & ie_ff[IE_GLOBAL_BIT]; // RQ6 RQ7
        end
    endgenerate

    assign irq_accept = acc_vec;

    // any cycle with no external kind may go quiet; external cycles keep the strobe
    assign strobe_needed = bus_cycle.data_move | bus_cycle.table_read
                         | bus_cycle.external_fetch; // RQ12

    always_comb
    begin
        ale_mode = ALE_NORMAL;
        case ({aux_ff[AUX_ALE_OFF_BIT], strobe_needed})
            2'h2: ale_mode = ALE_QUIET; // RQ3
            default: ale_mode = ALE_NORMAL;
        endcase
    end

    // released pin is left to the pad's weak pull-up
    assign ale_oe = (ale_mode == ALE_NORMAL); // RQ13
    assign ale_out = ale_oe & ale_pulse;

    // interrupt gating
    chk_global_block: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ6
        !ie_ff[IE_GLOBAL_BIT] |-> irq_accept == 5'h00)
        else $error("interrupt accepted with global enable clear");

    chk_serial_gate: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ8
        ie_ff[IE_GLOBAL_BIT] |-> irq_accept.serial == (irq_req.serial & ie_ff[IE_SERIAL_BIT]))
        else $error("serial gate wrong");

    chk_timer_gate: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ9
        ie_ff[IE_GLOBAL_BIT] |-> irq_accept.timer0 == (irq_req.timer0 & ie_ff[IE_T0_BIT])
            && irq_accept.timer1 == (irq_req.timer1 & ie_ff[IE_T1_BIT]))
        else $error("timer gate wrong");

    chk_ext_gate: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ10 RQ7
        ie_ff[IE_GLOBAL_BIT] |-> irq_accept.ext0 == (irq_req.ext0 & ie_ff[IE_X0_BIT])
            && irq_accept.ext1 == (irq_req.ext1 & ie_ff[IE_X1_BIT]))
        else $error("external gate wrong");

    chk_ie_write: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ7 RQ14
        sfr_wr && sfr_addr == IRQ_EN_ADDR |=> ie_ff == ($past(sfr_wdata) & IE_WRITE_MASK))
        else $error("enable write not applied next cycle");

    // register writes land on the next edge and nothing else moves them
    chk_aux_write: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ1 RQ2 RQ3 RQ14
        sfr_wr && sfr_addr == AUX_CTRL_ADDR |=>
            low_consumption_select == $past(sfr_wdata[AUX_LOWCON_BIT])
            && external_xmem_select == $past(sfr_wdata[AUX_XMEM_BIT])
            && aux_ff[AUX_ALE_OFF_BIT] == $past(sfr_wdata[AUX_ALE_OFF_BIT]))
        else $error("auxiliary write not applied next cycle");

    chk_aux_hold: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ14
        !(sfr_wr && sfr_addr == AUX_CTRL_ADDR) |=> $stable(aux_ff))
        else $error("auxiliary register changed without a write");

    chk_ie_hold: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ14
        !(sfr_wr && sfr_addr == IRQ_EN_ADDR) |=> $stable(ie_ff))
        else $error("enable register changed without a write");

    chk_unmapped_write: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ14
        sfr_wr && !sfr_hit |=> $stable(aux_ff) && $stable(ie_ff))
        else $error("unmapped write changed a register");

    chk_aux_reserved: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ14
        (aux_ff & ~AUX_WRITE_MASK) == '0)
        else $error("reserved auxiliary bit stored");

    chk_ie_reserved: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ14
        (ie_ff & ~IE_WRITE_MASK) == '0)
        else $error("reserved enable bit stored");

    // latch strobe pin
    chk_ale_quiet: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ3 RQ13
        aux_ff[AUX_ALE_OFF_BIT] && bus_cycle.internal_fetch && !strobe_needed
            |-> !ale_oe && !ale_out)
        else $error("strobe driven while suppressed");

    chk_ale_restore: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ3
        !aux_ff[AUX_ALE_OFF_BIT] |-> ale_oe && ale_out == ale_pulse)
        else $error("strobe not restored with suppression off");

    chk_ale_kept: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ12
        strobe_needed |-> ale_oe && ale_out == ale_pulse)
        else $error("strobe lost on external cycle");

    chk_ale_released: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ13
        !ale_oe |-> !ale_out)
        else $error("strobe level shown on a released pin");

    // reset
    chk_reset_vals: assert property (@(posedge sys_clk) // RQ4 RQ11
        $rose(rst_b) |-> aux_ff == AUX_RESET && ie_ff == IE_RESET)
        else $error("reset values wrong");
endmodule

`default_nettype wire
